/* rtl/fotc_top.sv */
// function output timing control: registers, function selection, aux three drive, uncoupling
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "fotc_defs.svh"
module fotc_top #(
	parameter int TICK_CYCLES = `FOTC_TICK_CYCLES // cycles per common tick
) (
	input  wire logic                    I_SYS_CLK,
	input  wire logic                    I_RESET,
	input  wire fotc_pkg::fotc_apb_req_s I_APB,
	output fotc_pkg::fotc_apb_rsp_s      O_APB,
	input  wire logic                    I_ANALOG_MODE,
	input  wire logic [13:0]             I_FUNC_KEYS,
	input  wire logic [7:0]              I_SPEED_CMD,
	input  wire logic                    I_POWER_RESTORED,
	output logic [13:0]                  O_FUNC_ACTIVE,
	output logic                         O_AUX_THREE,
	output logic [7:0]                   O_SPEED,
	output logic                         O_UNCOUPLE_ACTIVE,
	output logic                         O_UNCOUPLE_TOWARD_TRAIN,
	output logic                         O_ANALOG_DIR_FLAG,
	output logic                         O_FEEDBACK_ENABLE,
	output logic [7:0]                   O_FEEDBACK_OPTIONS,
	output logic                         O_AUTO_REGISTER_ENABLE
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [7:0]          mask_lo;    // analogue functions one to eight
		logic [7:0]          mask_hi;    // analogue headlights, nine to twelve
		logic [7:0]          fb_opt;     // feedback channel options
		logic [7:0]          config_r;   // basic configuration
		logic [7:0]          pulse_cfg;  // pulse sequence control
		logic [7:0]          retain;     // power-loss retention control
		logic [7:0]          dir_flag;   // analogue-to-digital direction
		logic [7:0]          unc_speed;  // uncoupling speed
		logic [7:0]          unc_remove; // remove duration
		logic [7:0]          unc_push;   // push duration
		logic [7:0]          auxiliary_output_three_delay; // on/off delay byte
		logic [7:0]          auxiliary_output_three_off;   // auto switch-off time
		logic [7:0]          auxiliary_output_three_bright;
		logic [7:0]          auxiliary_output_three_mode;
		logic [15:0]         prescale;   // common tick divider
		logic                tick;
		logic [31:0]         prdata;
		logic                perr;
		logic [13:0]         keys_q;     // last raw key state
		logic [13:0]         eff_q;      // last effective functions
		logic [13:0]         pulse_sel;  // toggled by pulse sequences
		logic [3:0]          pulse_cnt;
		logic [11:0]         gap;
		logic [13:0]         stored;     // functions kept for power loss
		logic [13:0]         restored;   // reapplied after power return
		logic                spd_hold;
		logic [7:0]          speed;
		fotc_pkg::fotc_unc_e unc;
		logic [17:0]         unc_cnt;
		logic                kick;
		logic [9:0]          kick_cnt;
		logic                aux_on_q;
		logic                auxiliary_output_three;
		logic [13:0]         funcs;
	} fotc_top_s;
	fotc_top_s s, next_s;

	logic [9:0]  idx;       // register index from the byte address
	logic        setup;     // first apb cycle
	logic        access;    // completing apb cycle
	logic [13:0] analog_fn; // masks laid out as function vector
	logic [13:0] digital_fn;
	logic [13:0] eff_fn;
	logic        tmr_on;    // aux three timer result
	logic        pwm;       // coupler reduced drive

	// ****************************************
	// helpers
	// ****************************************
	// true when an index names a register
	function automatic logic is_mapped(input logic [9:0] i);
		case (i)
			`FOTC_IDX_RESET, `FOTC_IDX_MASK_LO, `FOTC_IDX_MASK_HI, `FOTC_IDX_FB_OPT,
			`FOTC_IDX_CONFIG, `FOTC_IDX_PULSE_CFG, `FOTC_IDX_RETAIN, `FOTC_IDX_DIR_FLAG,
			`FOTC_IDX_UNC_SPEED, `FOTC_IDX_UNC_REMOVE, `FOTC_IDX_UNC_PUSH,
			`FOTC_IDX_AUXILIARY_OUTPUT_THREE_DELAY, `FOTC_IDX_AUXILIARY_OUTPUT_THREE_OFF, `FOTC_IDX_AUXILIARY_OUTPUT_THREE_BRIGHT,
			`FOTC_IDX_AUXILIARY_OUTPUT_THREE_MODE: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	// factory settings, used at reset and on the reset command
	function automatic fotc_top_s defaults(input fotc_top_s cur);
		defaults = cur;
		defaults.mask_lo = `FOTC_DEF_MASK_LO;
		defaults.mask_hi = `FOTC_DEF_MASK_HI;
		defaults.fb_opt = `FOTC_DEF_FB_OPT;
		defaults.config_r = `FOTC_DEF_CONFIG;
		defaults.pulse_cfg = `FOTC_DEF_ZERO;
		defaults.retain = `FOTC_DEF_ZERO;
		defaults.dir_flag = `FOTC_DEF_ZERO;
		defaults.unc_speed = `FOTC_DEF_ZERO;
		defaults.unc_remove = `FOTC_DEF_ZERO;
		defaults.unc_push = `FOTC_DEF_ZERO;
		defaults.auxiliary_output_three_delay = `FOTC_DEF_ZERO;
		defaults.auxiliary_output_three_off = `FOTC_DEF_ZERO;
		defaults.auxiliary_output_three_bright = `FOTC_DEF_ZERO;
		defaults.auxiliary_output_three_mode = `FOTC_DEF_ZERO;
	endfunction : defaults

	// ****************************************
	// decode and function selection
	// ****************************************
	assign idx = I_APB.paddr[11:2];
	assign setup = I_APB.psel && !I_APB.penable;
	assign access = I_APB.psel && I_APB.penable;
	// mask bytes as pressed keys in analogue mode
	assign analog_fn = {s.mask_hi[5:2], s.mask_lo, s.mask_hi[1:0]};
	// pulse mode swallows key one and uses its toggled selections
	assign digital_fn = s.pulse_cfg[`FOTC_BIT_PULSE] ?
		((I_FUNC_KEYS & ~(14'h1 << `FOTC_FN_KEY_ONE)) | s.pulse_sel) : I_FUNC_KEYS;
	assign eff_fn = (I_ANALOG_MODE ? analog_fn : digital_fn) | s.restored;

	// ****************************************
	// aux three timer and coupler pwm
	// ****************************************
	fotc_out_timer u_timer (
		.i_clk      (I_SYS_CLK),
		.i_rst      (I_RESET),
		.i_tick     (s.tick),
		.i_key      (eff_fn[`FOTC_FN_AUXILIARY_OUTPUT_THREE]),
		.i_delay    (s.auxiliary_output_three_delay),
		.i_auto_off (s.auxiliary_output_three_off),
		.o_on       (tmr_on)
	);

	fotc_pwm u_pwm (
		.i_clk  (I_SYS_CLK),
		.i_rst  (I_RESET),
		.i_duty (s.auxiliary_output_three_bright[4:0]),
		.o_pwm  (pwm)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic aux_req;
		aux_req = 1'b0;
		next_s = s;

		// common tick for every timer
		next_s.tick = 1'b0;
		if (s.prescale == 16'(TICK_CYCLES - 1)) begin
			next_s.prescale = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.prescale = 16'(s.prescale + 16'h1);
		end

		// apb read data and error latched in setup, shown in access
		if (setup) begin
			next_s.perr = !is_mapped(idx);
			case (idx)
				`FOTC_IDX_RESET:       next_s.prdata = {24'h0, `FOTC_ID_VALUE};
				`FOTC_IDX_MASK_LO:     next_s.prdata = {24'h0, s.mask_lo};
				`FOTC_IDX_MASK_HI:     next_s.prdata = {24'h0, s.mask_hi};
				`FOTC_IDX_FB_OPT:      next_s.prdata = {24'h0, s.fb_opt};
				`FOTC_IDX_CONFIG:      next_s.prdata = {24'h0, s.config_r};
				`FOTC_IDX_PULSE_CFG:   next_s.prdata = {24'h0, s.pulse_cfg};
				`FOTC_IDX_RETAIN:      next_s.prdata = {24'h0, s.retain};
				`FOTC_IDX_DIR_FLAG:    next_s.prdata = {24'h0, s.dir_flag};
				`FOTC_IDX_UNC_SPEED:   next_s.prdata = {24'h0, s.unc_speed};
				`FOTC_IDX_UNC_REMOVE:  next_s.prdata = {24'h0, s.unc_remove};
				`FOTC_IDX_UNC_PUSH:    next_s.prdata = {24'h0, s.unc_push};
				`FOTC_IDX_AUXILIARY_OUTPUT_THREE_DELAY:  next_s.prdata = {24'h0, s.auxiliary_output_three_delay};
				`FOTC_IDX_AUXILIARY_OUTPUT_THREE_OFF:    next_s.prdata = {24'h0, s.auxiliary_output_three_off};
				`FOTC_IDX_AUXILIARY_OUTPUT_THREE_BRIGHT: next_s.prdata = {24'h0, s.auxiliary_output_three_bright};
				`FOTC_IDX_AUXILIARY_OUTPUT_THREE_MODE:   next_s.prdata = {24'h0, s.auxiliary_output_three_mode};
				default:               next_s.prdata = '0; // unmapped reads zero
			endcase
		end

		// apb writes take effect at the access edge
		if (access && I_APB.pwrite && !s.perr) begin
			case (idx)
				`FOTC_IDX_RESET: begin
					// only the magic value restores defaults
					if (I_APB.pwdata[7:0] == `FOTC_RESET_MAGIC) begin
						next_s = defaults(next_s);
					end
				end
				`FOTC_IDX_MASK_LO:     next_s.mask_lo = I_APB.pwdata[7:0];
				`FOTC_IDX_MASK_HI:     next_s.mask_hi = I_APB.pwdata[7:0];
				`FOTC_IDX_FB_OPT:      next_s.fb_opt = I_APB.pwdata[7:0];
				`FOTC_IDX_CONFIG:      next_s.config_r = I_APB.pwdata[7:0];
				`FOTC_IDX_PULSE_CFG:   next_s.pulse_cfg = I_APB.pwdata[7:0];
				`FOTC_IDX_RETAIN:      next_s.retain = I_APB.pwdata[7:0];
				`FOTC_IDX_DIR_FLAG:    next_s.dir_flag = I_APB.pwdata[7:0];
				`FOTC_IDX_UNC_SPEED:   next_s.unc_speed = I_APB.pwdata[7:0];
				`FOTC_IDX_UNC_REMOVE:  next_s.unc_remove = I_APB.pwdata[7:0];
				`FOTC_IDX_UNC_PUSH:    next_s.unc_push = I_APB.pwdata[7:0];
				`FOTC_IDX_AUXILIARY_OUTPUT_THREE_DELAY:  next_s.auxiliary_output_three_delay = I_APB.pwdata[7:0];
				`FOTC_IDX_AUXILIARY_OUTPUT_THREE_OFF:    next_s.auxiliary_output_three_off = I_APB.pwdata[7:0];
				`FOTC_IDX_AUXILIARY_OUTPUT_THREE_BRIGHT: next_s.auxiliary_output_three_bright = I_APB.pwdata[7:0];
				`FOTC_IDX_AUXILIARY_OUTPUT_THREE_MODE:   next_s.auxiliary_output_three_mode = I_APB.pwdata[7:0];
				default: begin
					next_s.perr = s.perr; // refused earlier in setup
				end
			endcase
		end

		// pulse sequence: count key one presses, act after a quiet gap
		next_s.keys_q = I_FUNC_KEYS;
		if (!s.pulse_cfg[`FOTC_BIT_PULSE] || I_ANALOG_MODE) begin
			next_s.pulse_cnt = '0;
			next_s.gap = '0;
		end else if (I_FUNC_KEYS[`FOTC_FN_KEY_ONE] && !s.keys_q[`FOTC_FN_KEY_ONE]) begin
			if (s.pulse_cnt != `FOTC_PULSE_MAX) begin
				next_s.pulse_cnt = 4'(s.pulse_cnt + 4'h1);
			end
			next_s.gap = '0;
		end else if (s.tick && (s.pulse_cnt != 4'h0)) begin
			if (s.gap == 12'(`FOTC_PULSE_GAP_TICKS - 1)) begin
				// count n toggles function n, which sits at bit n+1
				next_s.pulse_sel[4'(s.pulse_cnt + 4'h1)] = !s.pulse_sel[4'(s.pulse_cnt + 4'h1)];
				next_s.pulse_cnt = '0;
				next_s.gap = '0;
			end else begin
				next_s.gap = 12'(s.gap + 12'h1);
			end
		end

		// retention of functions and speed over power loss
		next_s.eff_q = eff_fn;
		next_s.stored = eff_fn;
		if (I_POWER_RESTORED) begin
			next_s.restored = s.retain[`FOTC_BIT_KEEP_FUNC] ? s.stored : 14'h0;
			next_s.spd_hold = s.retain[`FOTC_BIT_KEEP_SPEED];
		end else if (I_FUNC_KEYS != s.keys_q) begin
			next_s.restored = '0; // fresh key activity takes over
		end
		if (!s.retain[`FOTC_BIT_KEEP_SPEED]) begin
			next_s.spd_hold = 1'b0;
		end
		// station speed ignored while the kept speed is held
		if (!next_s.spd_hold) begin
			next_s.speed = I_SPEED_CMD;
		end

		// automatic uncoupling sequence
		case (s.unc)
			fotc_pkg::UNC_IDLE: begin
				next_s.unc_cnt = '0;
				// zero speed leaves the sequence dead
				if (eff_fn[`FOTC_FN_UNCOUPLE] && !s.eff_q[`FOTC_FN_UNCOUPLE] &&
					(s.unc_speed != 8'h0)) begin
					next_s.unc = fotc_pkg::UNC_PUSH;
				end
			end
			fotc_pkg::UNC_PUSH: begin
				if (s.unc_cnt >= fotc_pkg::fotc_scale(s.unc_push, 12'(`FOTC_UNC_TICKS))) begin
					next_s.unc = fotc_pkg::UNC_REMOVE; // push time from its register
					next_s.unc_cnt = '0;
				end else if (s.tick) begin
					next_s.unc_cnt = 18'(s.unc_cnt + 18'h1);
				end
			end
			fotc_pkg::UNC_REMOVE: begin
				if (s.unc_cnt >= fotc_pkg::fotc_scale(s.unc_remove, 12'(`FOTC_UNC_TICKS))) begin
					next_s.unc = fotc_pkg::UNC_IDLE; // remove time from its register
				end else if (s.tick) begin
					next_s.unc_cnt = 18'(s.unc_cnt + 18'h1);
				end
			end
			default: begin
				next_s.unc = fotc_pkg::UNC_IDLE;
			end
		endcase

		// aux three drive, coupler kick then reduced pwm
		// the coupler fires while pushing, relying on coupler mode being set
		aux_req = tmr_on || (s.unc == fotc_pkg::UNC_PUSH);
		next_s.aux_on_q = aux_req;
		if (aux_req && !s.aux_on_q) begin
			next_s.kick = 1'b1;
			next_s.kick_cnt = '0;
		end else if (s.kick && s.tick) begin
			if (s.kick_cnt == 10'(`FOTC_KICK_TICKS - 1)) begin
				next_s.kick = 1'b0; // full power ends after 250 ms
			end else begin
				next_s.kick_cnt = 10'(s.kick_cnt + 10'h1);
			end
		end
		if (!s.auxiliary_output_three_mode[`FOTC_BIT_COUPLER]) begin
			next_s.auxiliary_output_three = aux_req;
		end else begin
			next_s.auxiliary_output_three = aux_req && (next_s.kick || pwm);
		end
		next_s.funcs = eff_fn;
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			s <= defaults('{unc: fotc_pkg::UNC_IDLE, default: '0});
		end else begin
			s <= next_s;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign O_APB.pready = 1'b1; // zero wait states
	assign O_APB.prdata = s.prdata;
	assign O_APB.pslverr = s.perr && access;
	assign O_FUNC_ACTIVE = s.funcs;
	assign O_AUX_THREE = s.auxiliary_output_three;
	// uncoupling overrides the speed while the sequence runs
	assign O_SPEED = (s.unc == fotc_pkg::UNC_IDLE) ? s.speed : s.unc_speed;
	assign O_UNCOUPLE_ACTIVE = (s.unc != fotc_pkg::UNC_IDLE);
	assign O_UNCOUPLE_TOWARD_TRAIN = (s.unc == fotc_pkg::UNC_PUSH);
	assign O_ANALOG_DIR_FLAG = s.dir_flag[`FOTC_BIT_DIR];
	assign O_FEEDBACK_ENABLE = s.config_r[`FOTC_BIT_FB_EN];
	assign O_FEEDBACK_OPTIONS = s.fb_opt;
	// registration needs the channel and its own bit
	assign O_AUTO_REGISTER_ENABLE = s.config_r[`FOTC_BIT_FB_EN] && s.fb_opt[`FOTC_BIT_AUTO_REG];
endmodule : fotc_top
`default_nettype wire

/* rtl/fotc_defs.svh */
// constants of the function output timing control block
// Behaviour
// - auto switch-off after N times 0.4 s
// - switch-on delay before output turns on
// - switch-off delay before output turns off
// - delay byte: on bits 0-3, off 4-7
// - coupler: full power 250 ms, then PWM
// - coupler duty from brightness, 0 off, 31 on
// - coupler reduced drive is high-frequency PWM
// - uncouple: push for push time, then remove
// - uncouple speed register, zero disables sequence
// - remove time and push time registers
// - analogue mode presses masked functions
// - defaults: headlights and function one in analogue
// - writing 8 to reset register loads defaults
// - direction flag bit for analogue-to-digital transit
// - retain functions bit 0, speed bit 1
// - retained speed overrides station speed commands
// - feedback channel needs enable bit 3
// - auto registration off when bit 7 clear
`ifndef FOTC_DEFS_SVH
`define FOTC_DEFS_SVH

// ****************************************
// register indices (byte address = index * 4)
// ****************************************
`define FOTC_IDX_RESET       10'h008
`define FOTC_IDX_MASK_LO     10'h00D
`define FOTC_IDX_MASK_HI     10'h00E
`define FOTC_IDX_FB_OPT      10'h01C
`define FOTC_IDX_CONFIG      10'h01D
`define FOTC_IDX_PULSE_CFG   10'h031
`define FOTC_IDX_RETAIN      10'h07A
`define FOTC_IDX_DIR_FLAG    10'h07C
`define FOTC_IDX_UNC_SPEED   10'h0F6
`define FOTC_IDX_UNC_REMOVE  10'h0F7
`define FOTC_IDX_UNC_PUSH    10'h0F8
`define FOTC_IDX_AUXILIARY_OUTPUT_THREE_DELAY  10'h124
`define FOTC_IDX_AUXILIARY_OUTPUT_THREE_OFF    10'h125
`define FOTC_IDX_AUXILIARY_OUTPUT_THREE_BRIGHT 10'h126
`define FOTC_IDX_AUXILIARY_OUTPUT_THREE_MODE   10'h127

// ****************************************
// values and field positions
// ****************************************
`define FOTC_RESET_MAGIC     8'h08
`define FOTC_ID_VALUE        8'h5A
`define FOTC_DEF_MASK_LO     8'h01
`define FOTC_DEF_MASK_HI     8'h03
`define FOTC_DEF_FB_OPT      8'h80
`define FOTC_DEF_CONFIG      8'h08
`define FOTC_DEF_ZERO        8'h00
`define FOTC_BIT_FB_EN       3
`define FOTC_BIT_AUTO_REG    7
`define FOTC_BIT_PULSE       5
`define FOTC_BIT_KEEP_FUNC   0
`define FOTC_BIT_KEEP_SPEED  1
`define FOTC_BIT_DIR         0
`define FOTC_BIT_COUPLER     0
`define FOTC_FN_KEY_ONE      2
`define FOTC_FN_AUXILIARY_OUTPUT_THREE         4
`define FOTC_FN_UNCOUPLE     5
`define FOTC_PULSE_MAX       4'hC

// ****************************************
// timing
// ****************************************
`define FOTC_CLK_MHZ         100
`define FOTC_TICK_US         400
`define FOTC_AUTO_OFF_US     400000
`define FOTC_DELAY_STEP_US   409600
`define FOTC_KICK_US         250000
`define FOTC_UNC_UNIT_US     400000
`define FOTC_PULSE_GAP_US    1000000
`define FOTC_TICK_CYCLES     (`FOTC_TICK_US * `FOTC_CLK_MHZ)
`define FOTC_AUTO_OFF_TICKS  (`FOTC_AUTO_OFF_US / `FOTC_TICK_US)
`define FOTC_DELAY_TICKS     (`FOTC_DELAY_STEP_US / `FOTC_TICK_US)
`define FOTC_KICK_TICKS      (`FOTC_KICK_US / `FOTC_TICK_US)
`define FOTC_UNC_TICKS       (`FOTC_UNC_UNIT_US / `FOTC_TICK_US)
`define FOTC_PULSE_GAP_TICKS (`FOTC_PULSE_GAP_US / `FOTC_TICK_US)

`endif

/* rtl/fotc_pkg.sv */
// types shared by the function output timing control block
`include "fotc_defs.svh"
package fotc_pkg;
	// apb request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} fotc_apb_req_s;
	// apb answer to the master
	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} fotc_apb_rsp_s;
	// output timer states
	typedef enum logic [2:0] {TMR_OFF, TMR_WAIT_ON, TMR_ON, TMR_WAIT_OFF, TMR_FORCED} fotc_tmr_e;
	// uncoupling sequence states
	typedef enum logic [1:0] {UNC_IDLE, UNC_PUSH, UNC_REMOVE} fotc_unc_e;
	// scale a register value by a tick unit
	// operands widened first so the product is not cut to the operand width
	function automatic logic [17:0] fotc_scale(input logic [7:0] v, input logic [11:0] unit);
		fotc_scale = 18'(18'(v) * 18'(unit));
	endfunction : fotc_scale
endpackage : fotc_pkg

/* rtl/fotc_pwm.sv */
// coupler drive pwm generator
`timescale 1ns/1ps
`default_nettype none
module fotc_pwm (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic [4:0] i_duty,
	output logic            o_pwm
);
	// state: free running phase and registered output
	typedef struct packed {
		logic [4:0] phase;
		logic       pwm;
	} fotc_pwm_s;
	fotc_pwm_s s, next_s;

	// phase runs 0..30 on every clock, so duty 31 never drops
	always_comb begin
		next_s = s;
		next_s.phase = (s.phase == 5'h1E) ? 5'h00 : 5'(s.phase + 5'h01); // fast carrier
		next_s.pwm = (s.phase < i_duty); // 0 stays off
	end

	// state register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_pwm = s.pwm;
endmodule : fotc_pwm
`default_nettype wire

/* rtl/fotc_out_timer.sv */
// per-output switch-on, switch-off and auto switch-off timer
`timescale 1ns/1ps
`default_nettype none
`include "fotc_defs.svh"
module fotc_out_timer (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_tick,
	input  wire logic       i_key,
	input  wire logic [7:0] i_delay,
	input  wire logic [7:0] i_auto_off,
	output logic            o_on
);
	// state: phase, last key and tick count since last change
	typedef struct packed {
		fotc_pkg::fotc_tmr_e st;
		logic                key_q;
		logic [17:0]         cnt;
		logic                on;
	} fotc_tmr_s;
	fotc_tmr_s s, next_s;
	logic [17:0] on_ticks;  // switch-on wait
	logic [17:0] off_ticks; // switch-off wait
	logic [17:0] auto_ticks;

	// field split of the delay byte
	assign on_ticks = fotc_pkg::fotc_scale({4'h0, i_delay[3:0]}, 12'(`FOTC_DELAY_TICKS));
	assign off_ticks = fotc_pkg::fotc_scale({4'h0, i_delay[7:4]}, 12'(`FOTC_DELAY_TICKS));
	assign auto_ticks = fotc_pkg::fotc_scale(i_auto_off, 12'(`FOTC_AUTO_OFF_TICKS));

	// timer sequencing
	always_comb begin
		next_s = s;
		next_s.key_q = i_key;
		if (i_key != s.key_q) begin
			// any key change restarts the count
			next_s.cnt = '0;
			if (i_key) begin
				next_s.st = (on_ticks == 18'h0) ? fotc_pkg::TMR_ON : fotc_pkg::TMR_WAIT_ON;
			end else if ((s.st == fotc_pkg::TMR_ON) && (off_ticks != 18'h0)) begin
				next_s.st = fotc_pkg::TMR_WAIT_OFF; // hold on for the off delay
			end else begin
				next_s.st = fotc_pkg::TMR_OFF;
			end
		end else if (i_tick) begin
			next_s.cnt = 18'(s.cnt + 18'h1);
			case (s.st)
				fotc_pkg::TMR_WAIT_ON: begin
					if (next_s.cnt >= on_ticks) begin // on after delay
						next_s.st = fotc_pkg::TMR_ON;
						next_s.cnt = '0;
					end
				end
				fotc_pkg::TMR_ON: begin
					// zero disables the forced switch-off
					if ((auto_ticks != 18'h0) && (next_s.cnt >= auto_ticks)) begin
						next_s.st = fotc_pkg::TMR_FORCED;
					end
				end
				fotc_pkg::TMR_WAIT_OFF: begin
					if (next_s.cnt >= off_ticks) begin
						next_s.st = fotc_pkg::TMR_OFF;
					end
				end
				default: begin
					next_s.cnt = s.cnt; // idle phases do not count
				end
			endcase
		end
		next_s.on = (next_s.st == fotc_pkg::TMR_ON) || (next_s.st == fotc_pkg::TMR_WAIT_OFF);
	end

	// state register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s <= '{st: fotc_pkg::TMR_OFF, key_q: 1'b0, cnt: '0, on: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign o_on = s.on;
endmodule : fotc_out_timer
`default_nettype wire

/* tb/fotc_asserts.sv */
// port assertions of the function output timing control top
`timescale 1ns/1ps
`default_nettype none
module fotc_asserts (
	input wire logic                    I_SYS_CLK,
	input wire logic                    I_RESET,
	input wire fotc_pkg::fotc_apb_req_s I_APB,
	input wire logic [7:0]              O_SPEED,
	input wire logic                    O_UNCOUPLE_ACTIVE,
	input wire logic                    O_UNCOUPLE_TOWARD_TRAIN,
	input wire logic                    O_ANALOG_DIR_FLAG,
	input wire logic                    O_FEEDBACK_ENABLE,
	input wire logic [7:0]              O_FEEDBACK_OPTIONS,
	input wire logic                    O_AUTO_REGISTER_ENABLE
);
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RESET);
	// write in its access phase: the only moment a register changes
	logic wr;
	assign wr = I_APB.psel & I_APB.penable & I_APB.pwrite;
	AST_RST_DEF: assert property ($fell(I_RESET) |-> O_FEEDBACK_ENABLE && O_AUTO_REGISTER_ENABLE
		&& O_FEEDBACK_OPTIONS == 8'h80 && !O_UNCOUPLE_ACTIVE) else $error("bad reset values");
	AST_FACTORY: assert property (wr && I_APB.paddr == 12'h020 && I_APB.pwdata[7:0] == 8'h08
		|=> O_FEEDBACK_OPTIONS == 8'h80 && O_FEEDBACK_ENABLE) else $error("defaults not restored");
	AST_FB_EN: assert property (wr && I_APB.paddr == 12'h074
		|=> O_FEEDBACK_ENABLE == $past(I_APB.pwdata[3])) else $error("feedback enable wrong");
	AST_AUTO_REG: assert property (wr && I_APB.paddr == 12'h070
		|=> O_AUTO_REGISTER_ENABLE == ($past(I_APB.pwdata[7]) && O_FEEDBACK_ENABLE))
		else $error("registration wrong");
	AST_DIR: assert property (wr && I_APB.paddr == 12'h1F0
		|=> O_ANALOG_DIR_FLAG == $past(I_APB.pwdata[0])) else $error("direction flag wrong");
	AST_UNC_SPEED: assert property (O_UNCOUPLE_ACTIVE |-> O_SPEED != 8'h00)
		else $error("uncoupling at zero speed");
	AST_UNC_START: assert property ($rose(O_UNCOUPLE_ACTIVE) |-> O_UNCOUPLE_TOWARD_TRAIN)
		else $error("uncoupling did not start pushing");
	AST_UNC_END: assert property ($fell(O_UNCOUPLE_ACTIVE) |-> !$past(O_UNCOUPLE_TOWARD_TRAIN))
		else $error("uncoupling ended while pushing");
endmodule : fotc_asserts
bind fotc_top fotc_asserts i_fotc_asserts (.I_SYS_CLK, .I_RESET, .I_APB, .O_SPEED,
	.O_UNCOUPLE_ACTIVE, .O_UNCOUPLE_TOWARD_TRAIN, .O_ANALOG_DIR_FLAG, .O_FEEDBACK_ENABLE,
	.O_FEEDBACK_OPTIONS, .O_AUTO_REGISTER_ENABLE);
`default_nettype wire

/* tb/fotc_station.sv */
// command station model: key and speed commands reach the decoder a cycle late
`timescale 1ns/1ps
`default_nettype none
module fotc_station (
	input  wire logic        i_clk,
	input  wire logic [13:0] i_keys,
	input  wire logic [7:0]  i_speed,
	output logic      [13:0] o_keys,
	output logic      [7:0]  o_speed
);
	// one packet per clock, so commands always lag the request
	always @(posedge i_clk) begin
		o_keys  <= i_keys;
		o_speed <= i_speed;
	end
endmodule : fotc_station
`default_nettype wire

/* tb/test_function_output_timing_control.sv */
// self-checking bench of the function output timing control block
`timescale 1ns/1ps
`default_nettype none
`include "fotc_defs.svh"
module test_function_output_timing_control;
	localparam int TCK = 4; // short tick keeps timers in reach
	logic                    clk, rst, ana, pwr, se, aux, ua, ut, dirf, fbe, are;
	logic [13:0]             keys, st_keys, fa;
	logic [7:0]              spd, st_spd, sout;
	logic [31:0]             rd;
	fotc_pkg::fotc_apb_req_s req;
	fotc_pkg::fotc_apb_rsp_s rsp;
	logic [11:0] adr [7] = '{12'h034, 12'h038, 12'h1E8, 12'h3D8, 12'h3DC, 12'h3E0, 12'h490};
	int err_count, compares, n, e, mdl[int];
	int seed = 22090;
	fotc_station i_fotc_station (.i_clk(clk), .i_keys(keys), .i_speed(spd), .o_keys(st_keys),
		.o_speed(st_spd));
	fotc_top #(.TICK_CYCLES(TCK)) i_fotc_top (.I_SYS_CLK(clk), .I_RESET(rst), .I_APB(req),
		.O_APB(rsp), .I_ANALOG_MODE(ana), .I_FUNC_KEYS(st_keys), .I_SPEED_CMD(st_spd),
		.I_POWER_RESTORED(pwr), .O_FUNC_ACTIVE(fa), .O_AUX_THREE(aux), .O_SPEED(sout),
		.O_UNCOUPLE_ACTIVE(ua), .O_UNCOUPLE_TOWARD_TRAIN(ut), .O_ANALOG_DIR_FLAG(dirf),
		.O_FEEDBACK_ENABLE(fbe), .O_FEEDBACK_OPTIONS(), .O_AUTO_REGISTER_ENABLE(are));
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			err_count++;
			$display("mismatch %0t seen %h want %h", $time, s, x);
		end
	endtask : chk
	// one apb transfer, held until pready, then an idle cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (rsp.pready !== 1'b1); // only the watchdog ends a hang
		rd = rsp.prdata;
		se = rsp.pslverr;
		req <= '0;
		@(posedge clk);
	endtask : apb
	task automatic wreg(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
		mdl[a] = int'(d);
	endtask : wreg
	task automatic rchk(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
		chk(rd, mdl[a]);
	endtask : rchk
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
	endtask : cyc
	// high cycles of aux three over two pwm periods
	task automatic cnt();
		n = 0;
		repeat (62) begin
			@(posedge clk);
			n += int'(aux === 1'b1);
		end
	endtask : cnt
	task automatic wrap_up();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// whole run is about 42k cycles
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		wrap_up();
	end
	initial begin
		{rst, ana, pwr, keys, spd, req} = {1'b1, 2'b00, 14'h0, 8'h0, 47'h0};
		mdl[12'h034] = 1;
		mdl[12'h038] = 3;
		mdl[12'h020] = `FOTC_ID_VALUE;
		cyc(10);
		rst <= 1'b0;
		rchk(12'h034);
		rchk(12'h038);
		rchk(12'h020);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0);
		chk(se, 1'b1);
		foreach (adr[i]) begin
			wreg(adr[i], 8'($random(seed)));
			rchk(adr[i]);
		end
		wreg(12'h3D8, 8'h00); // random masks must not start an uncouple run
		ana <= 1'b1;
		cyc(3);
		e = (mdl[12'h038] & 3) | ((mdl[12'h034] & 255) << 2) | (((mdl[12'h038] >> 2) & 15) << 10);
		chk(fa, e);
		ana <= 1'b0;
		apb(1'b1, 12'h020, 32'h8);
		foreach (adr[i]) mdl[adr[i]] = 0;
		mdl[12'h034] = 1;
		mdl[12'h038] = 3;
		rchk(12'h034);
		rchk(12'h3D8);
		wreg(12'h070, 8'h00);
		chk(are, 1'b0);
		wreg(12'h074, 8'h00);
		chk(fbe, 1'b0);
		wreg(12'h1F0, 8'h01);
		chk(dirf, 1'b1);
		wreg(12'h490, 8'h21);
		keys <= 14'h0010;
		cyc(4000);
		chk(aux, 1'b0);
		cyc(200);
		chk(aux, 1'b1);
		keys <= 14'h0;
		cyc(8100);
		chk(aux, 1'b1);
		cyc(200);
		chk(aux, 1'b0);
		wreg(12'h490, 8'h00);
		wreg(12'h494, 8'h01);
		keys <= 14'h0010;
		cyc(3920);
		chk(aux, 1'b1);
		cyc(200);
		chk(aux, 1'b0);
		keys <= 14'h0;
		wreg(12'h494, 8'h00);
		wreg(12'h49C, 8'h01);
		keys <= 14'h0010;
		cyc(100);
		chk(aux, 1'b1);
		cyc(2500);
		cnt();
		chk(n, 0);
		wreg(12'h498, 8'h1F);
		cyc(2); // pwm and output flops lag the write
		cnt();
		chk(n, 62);
		keys <= 14'h0;
		wreg(12'h3D8, 8'h40);
		wreg(12'h3E0, 8'h01);
		wreg(12'h3DC, 8'h02);
		keys <= 14'h0020;
		cyc(20);
		chk({ua, ut, sout}, 10'h340);
		cyc(4050);
		chk({ua, ut}, 2'b10);
		cyc(8050);
		chk(ua, 1'b0);
		keys <= 14'h0;
		wreg(12'h3D8, 8'h00);
		keys <= 14'h0020;
		cyc(20);
		chk(ua, 1'b0);
		spd <= 8'h33;
		wreg(12'h1E8, 8'h02);
		pwr <= 1'b1;
		cyc(1);
		pwr <= 1'b0;
		spd <= 8'h10;
		cyc(5);
		chk(sout, 8'h33);
		wreg(12'h0C4, 8'h20);
		keys <= 14'h0024;
		cyc(3);
		chk(fa, 14'h0020);
		keys <= 14'h0020;
		cyc(2);
		keys <= 14'h0024;
		cyc(2);
		keys <= 14'h0020;
		cyc(10100);
		chk(fa, 14'h0028);
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		cyc(2);
		chk(fbe, 1'b1);
		wrap_up();
	end
endmodule : test_function_output_timing_control
`default_nettype wire
